// *** fcd_defines.vh ***
// constants for the frequency and current detection flag block
`ifndef FCD_DEFINES_VH
`define FCD_DEFINES_VH

// =============================================
// clock and timebase
`define FCD_CLK_PERIOD_NS 8
`define FCD_TICK_MS 10
`define FCD_TICK_NS (`FCD_TICK_MS * 1000000)
`define FCD_ZC_HOLD_MS 100

// =============================================
// setting select codes on the write port
`define FCD_SEL_BAND 4'h0
`define FCD_SEL_FWD_THR 4'h1
`define FCD_SEL_REV_THR 4'h2
`define FCD_SEL_OC_LEVEL 4'h3
`define FCD_SEL_OC_DELAY 4'h4
`define FCD_SEL_ZC_LEVEL 4'h5
`define FCD_SEL_ZC_TIME 4'h6
`define FCD_SEL_OC_RETAIN 4'h7
`define FCD_SEL_OC_ACTION 4'h8
`define FCD_SEL_TERM_A 4'h9
`define FCD_SEL_TERM_B 4'ha

// =============================================
// reset values (freq in 0.1 Hz, time in 10 ms ticks, level in %)
`define FCD_RST_BAND 7'h0a
`define FCD_RST_FWD_THR 16'h003c
`define FCD_RST_REV_THR 16'h270f
`define FCD_RST_OC_LEVEL 8'h96
`define FCD_RST_OC_DELAY 14'h0000
`define FCD_RST_ZC_LEVEL 8'h05
`define FCD_RST_ZC_TIME 14'h0032
`define FCD_RST_OC_RETAIN 14'h000a
`define FCD_RST_OC_ACTION 1'b0
`define FCD_RST_TERM_A 8'h00
`define FCD_RST_TERM_B 8'h63

// =============================================
// setting limits and sentinels
`define FCD_MAX_BAND 16'h0064
`define FCD_MAX_FREQ 16'h0fa0
`define FCD_MAX_LEVEL 16'h00c8
`define FCD_MAX_OC_TIME 16'h03e8
`define FCD_MAX_ZC_TIME 16'h0064
`define FCD_MAX_TERM 16'h00c7
`define FCD_SENTINEL 16'h270f
`define FCD_GATE_OPEN 16'h0000

// =============================================
// terminal function codes
`define FCD_CODE_RUN 8'h00
`define FCD_CODE_SU 8'h01
`define FCD_CODE_FU 8'h04
`define FCD_CODE_OC 8'h0c
`define FCD_CODE_ZC 8'h0d
`define FCD_CODE_NEG 8'h64

`endif

// *** fcd_flags_props.sv ***
// port-level assertions for the detection flag block
`timescale 1ns/10ps
`include "fcd_defines.vh"
module fcd_flags_chk (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // drive state and settings port
   input wire running,
   input wire fault_reset,
   input wire dc_brake_active,
   input wire [15:0] extended_settings_gate,
   input wire set_wr,
   input wire [3:0] set_sel,
   input wire [15:0] set_data,
   // results
   input wire set_wr_refused_r,
   input wire at_speed_flag_r,
   input wire freq_level_flag_r,
   input wire overcurrent_level_flag_r,
   input wire zero_current_flag_r,
   input wire current_detect_fault_r,
   input wire term_a_on
);
   // ==========================================
   // shadow of the terminal a code, so terminal checks know the polarity
   reg [7:0] code_a_r;
   wire gate_open = (extended_settings_gate == `FCD_GATE_OPEN);
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code_a_r <= `FCD_RST_TERM_A;
      end else if (set_wr && gate_open && set_sel == `FCD_SEL_TERM_A && set_data <= `FCD_MAX_TERM) begin
         code_a_r <= set_data[7:0];
      end
   end
   // retention shadow: short or latched hold makes the minimum-on check moot
   reg [15:0] retain_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         retain_r <= {2'b00, `FCD_RST_OC_RETAIN};
      end else if (set_wr && gate_open && set_sel == `FCD_SEL_OC_RETAIN &&
         (set_data <= `FCD_MAX_OC_TIME || set_data == `FCD_SENTINEL)) begin
         retain_r <= set_data;
      end
   end
   wire long_retain = (retain_r >= 16'h0008) && (retain_r != `FCD_SENTINEL);
   // ==========================================
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence oc_set;
      $rose(overcurrent_level_flag_r);
   endsequence
   sequence zc_set;
      $rose(zero_current_flag_r);
   endsequence
   chk_brake_clears_freq: assert property (dc_brake_active |=> !at_speed_flag_r && !freq_level_flag_r)
      else $error("frequency flag set during dc braking");
   chk_gate_refuse: assert property ((set_wr && !gate_open) |=> set_wr_refused_r)
      else $error("write with gate closed not refused");
   chk_write_taken: assert property ((set_wr && gate_open && set_sel <= `FCD_SEL_TERM_B && set_data == 16'h0000) |=> !set_wr_refused_r)
      else $error("legal write refused");
   chk_trip_with_flag: assert property ($rose(current_detect_fault_r) |-> oc_set)
      else $error("trip without overcurrent flag rising");
   chk_fault_reset_clears: assert property ((fault_reset && current_detect_fault_r) |=>
      !current_detect_fault_r || $rose(overcurrent_level_flag_r))
      else $error("fault not cleared by reset pulse");
   chk_oc_hold_time: assert property ((oc_set ##0 long_retain) |=> overcurrent_level_flag_r[*8])
      else $error("overcurrent flag dropped too soon");
   chk_oc_needs_run: assert property (oc_set |-> $past(running, 2))
      else $error("overcurrent flag rose while stopped");
   chk_zc_hold_time: assert property (zc_set |=> zero_current_flag_r[*8])
      else $error("zero current flag dropped too soon");
   chk_zc_needs_run: assert property (zc_set |-> $past(running, 2))
      else $error("zero current flag rose while stopped");
   chk_term_oc_pos: assert property (($past(code_a_r) == `FCD_CODE_OC) |-> term_a_on == $past(overcurrent_level_flag_r))
      else $error("terminal a does not follow overcurrent flag");
   chk_term_oc_neg: assert property (($past(code_a_r) == (`FCD_CODE_OC + `FCD_CODE_NEG)) |-> term_a_on == !$past(overcurrent_level_flag_r))
      else $error("terminal a not inverted for negative code");
endmodule // fcd_flags_chk

bind fcd_top fcd_flags_chk u_fcd_flags_chk (.clk(clk), .rst_n(rst_n), .running(running),
   .fault_reset(fault_reset), .dc_brake_active(dc_brake_active),
   .extended_settings_gate(extended_settings_gate), .set_wr(set_wr), .set_sel(set_sel),
   .set_data(set_data), .set_wr_refused_r(set_wr_refused_r), .at_speed_flag_r(at_speed_flag_r),
   .freq_level_flag_r(freq_level_flag_r), .overcurrent_level_flag_r(overcurrent_level_flag_r),
   .zero_current_flag_r(zero_current_flag_r), .current_detect_fault_r(current_detect_fault_r),
   .term_a_on(term_a_on));

// *** fcd_machine_ctrl.sv ***
// machine controller model reading the two output terminals
`timescale 1ns/10ps
module fcd_machine_ctrl (
   // clock
   input wire clk,
   // codes this controller loaded into the terminal selects
   input wire [7:0] code_a,
   input wire [7:0] code_b,
   // terminals, 1 = conducting
   input wire term_a_on,
   input wire term_b_on,
   // flag states as read back
   output reg flag_a_seen_r,
   output reg flag_b_seen_r
);
   // negative codes conduct while the flag is off, so undo that here
   always @(posedge clk) begin
      flag_a_seen_r <= term_a_on ^ (code_a >= 8'h64);
      flag_b_seen_r <= term_b_on ^ (code_b >= 8'h64);
   end
endmodule // fcd_machine_ctrl

// *** fcd_qual_timer.v ***
// qualifying timer: condition must hold for a number of ticks
`timescale 1ns/10ps
module fcd_qual_timer (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // timing
   input wire tick,
   input wire [13:0] limit,
   // condition in, qualified out
   input wire cond,
   output reg qualified_r
);
   reg [13:0] cnt_r;

   // =============================================
   // counter restarts whenever the condition drops
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 14'h0000;
         qualified_r <= 1'b0;
      end else begin
         if (!cond) begin
            cnt_r <= 14'h0000;
         end else if (tick && cnt_r != 14'h3fff) begin
            cnt_r <= cnt_r + 14'h0001;
         end
         qualified_r <= cond && (cnt_r >= limit);
      end
   end
endmodule // fcd_qual_timer

// *** fcd_term_drive.v ***
// output terminal driver: function code picks a flag and its polarity
`timescale 1ns/10ps
`include "fcd_defines.vh"
module fcd_term_drive (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // function code 0..199
   input wire [7:0] func_code,
   // flags
   input wire running,
   input wire at_speed,
   input wire freq_level,
   input wire oc_level,
   input wire zc_level,
   // terminal conducting
   output reg term_on_r
);
   reg [7:0] base;
   reg neg;
   reg sel_flag;

   always @* begin
      neg = (func_code >= `FCD_CODE_NEG);
      base = neg ? (func_code - `FCD_CODE_NEG) : func_code;
      if (base == `FCD_CODE_RUN) begin
         sel_flag = running;
      end else if (base == `FCD_CODE_SU) begin
         sel_flag = at_speed;
      end else if (base == `FCD_CODE_FU) begin
         sel_flag = freq_level;
      end else if (base == `FCD_CODE_OC) begin
         sel_flag = oc_level;
      end else if (base == `FCD_CODE_ZC) begin
         sel_flag = zc_level;
      end else begin
         sel_flag = 1'b0;
      end
   end

   // =============================================
   // unassigned codes leave the terminal off in either polarity
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         term_on_r <= 1'b0;
      end else if (neg) begin
         term_on_r <= !sel_flag && (base == `FCD_CODE_RUN || base == `FCD_CODE_SU ||
            base == `FCD_CODE_FU || base == `FCD_CODE_OC || base == `FCD_CODE_ZC);
      end else begin
         term_on_r <= sel_flag;
      end
   end
endmodule // fcd_term_drive

// *** fcd_top.v ***
// frequency and current detection flags with two output terminals
`timescale 1ns/10ps
`include "fcd_defines.vh"
module fcd_top #(
   parameter integer TICK_CYCLES = `FCD_TICK_NS / `FCD_CLK_PERIOD_NS
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // drive state
   input wire running,
   input wire start_cmd,
   input wire fault_reset,
   input wire rev_dir,
   input wire dc_brake_active,
   // frequencies in 0.1 Hz, output taken before slip compensation
   input wire [15:0] out_freq_raw,
   input wire [15:0] set_freq,
   // currents in the same unit
   input wire [15:0] out_current,
   input wire [15:0] rated_current,
   // settings write port
   input wire [15:0] extended_settings_gate,
   input wire set_wr,
   input wire [3:0] set_sel,
   input wire [15:0] set_data,
   output reg set_wr_refused_r,
   // flags
   output reg at_speed_flag_r,
   output reg freq_level_flag_r,
   output reg overcurrent_level_flag_r,
   output reg zero_current_flag_r,
   output reg current_detect_fault_r,
   // terminals
   output wire term_a_on,
   output wire term_b_on
);
   // =============================================
   // scaled product used for every percentage comparison
   function [23:0] scale;
      input [15:0] val;
      input [7:0] pct;
      begin
         scale = val * pct;
      end
   endfunction

   // =============================================
   // settings
   reg [6:0] at_speed_band_setting_r;
   reg [15:0] fwd_freq_threshold_r;
   reg [15:0] rev_freq_threshold_r;
   reg [7:0] overcurrent_level_setting_r;
   reg [13:0] overcurrent_delay_setting_r;
   reg [7:0] zero_current_level_setting_r;
   reg [13:0] zero_current_time_setting_r;
   reg [13:0] overcurrent_retention_setting_r;
   reg overcurrent_action_select_r;
   reg [7:0] terminal_function_select_a_r;
   reg [7:0] terminal_function_select_b_r;
   reg wr_ok;
   reg [15:0] wr_max;

   always @* begin
      if (set_sel == `FCD_SEL_BAND) begin
         wr_max = `FCD_MAX_BAND;
      end else if (set_sel == `FCD_SEL_FWD_THR || set_sel == `FCD_SEL_REV_THR) begin
         wr_max = `FCD_MAX_FREQ;
      end else if (set_sel == `FCD_SEL_OC_LEVEL || set_sel == `FCD_SEL_ZC_LEVEL) begin
         wr_max = `FCD_MAX_LEVEL;
      end else if (set_sel == `FCD_SEL_OC_DELAY || set_sel == `FCD_SEL_OC_RETAIN) begin
         wr_max = `FCD_MAX_OC_TIME;
      end else if (set_sel == `FCD_SEL_ZC_TIME) begin
         wr_max = `FCD_MAX_ZC_TIME;
      end else if (set_sel == `FCD_SEL_OC_ACTION) begin
         wr_max = 16'h0001;
      end else if (set_sel == `FCD_SEL_TERM_A || set_sel == `FCD_SEL_TERM_B) begin
         wr_max = `FCD_MAX_TERM;
      end else begin
         wr_max = 16'h0000;
      end
      // sentinel is legal only for reverse threshold and retention
      wr_ok = (extended_settings_gate == `FCD_GATE_OPEN) &&
         (set_sel <= `FCD_SEL_TERM_B) &&
         ((set_data <= wr_max) ||
          (set_data == `FCD_SENTINEL &&
           (set_sel == `FCD_SEL_REV_THR || set_sel == `FCD_SEL_OC_RETAIN)));
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         at_speed_band_setting_r <= `FCD_RST_BAND;
         fwd_freq_threshold_r <= `FCD_RST_FWD_THR;
         rev_freq_threshold_r <= `FCD_RST_REV_THR;
         overcurrent_level_setting_r <= `FCD_RST_OC_LEVEL;
         overcurrent_delay_setting_r <= `FCD_RST_OC_DELAY;
         zero_current_level_setting_r <= `FCD_RST_ZC_LEVEL;
         zero_current_time_setting_r <= `FCD_RST_ZC_TIME;
         overcurrent_retention_setting_r <= `FCD_RST_OC_RETAIN;
         overcurrent_action_select_r <= `FCD_RST_OC_ACTION;
         terminal_function_select_a_r <= `FCD_RST_TERM_A;
         terminal_function_select_b_r <= `FCD_RST_TERM_B;
         set_wr_refused_r <= 1'b0;
      end else begin
         set_wr_refused_r <= set_wr && !wr_ok;
         if (set_wr && wr_ok) begin
            if (set_sel == `FCD_SEL_BAND) begin
               at_speed_band_setting_r <= set_data[6:0];
            end else if (set_sel == `FCD_SEL_FWD_THR) begin
               fwd_freq_threshold_r <= set_data;
            end else if (set_sel == `FCD_SEL_REV_THR) begin
               rev_freq_threshold_r <= set_data;
            end else if (set_sel == `FCD_SEL_OC_LEVEL) begin
               overcurrent_level_setting_r <= set_data[7:0];
            end else if (set_sel == `FCD_SEL_OC_DELAY) begin
               overcurrent_delay_setting_r <= set_data[13:0];
            end else if (set_sel == `FCD_SEL_ZC_LEVEL) begin
               zero_current_level_setting_r <= set_data[7:0];
            end else if (set_sel == `FCD_SEL_ZC_TIME) begin
               zero_current_time_setting_r <= set_data[13:0];
            end else if (set_sel == `FCD_SEL_OC_RETAIN) begin
               overcurrent_retention_setting_r <= set_data[13:0];
            end else if (set_sel == `FCD_SEL_OC_ACTION) begin
               overcurrent_action_select_r <= set_data[0];
            end else if (set_sel == `FCD_SEL_TERM_A) begin
               terminal_function_select_a_r <= set_data[7:0];
            end else begin
               terminal_function_select_b_r <= set_data[7:0];
            end
         end
      end
   end

   // =============================================
   // 10 ms timebase; shorten TICK_CYCLES in simulation
   reg [20:0] tick_cnt_r;
   reg tick_r;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_r <= 21'h000000;
         tick_r <= 1'b0;
      end else if (tick_cnt_r >= TICK_CYCLES[20:0] - 21'h000001) begin
         tick_cnt_r <= 21'h000000;
         tick_r <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 21'h000001;
         tick_r <= 1'b0;
      end
   end

   // =============================================
   // frequency flags
   wire [15:0] freq_diff;
   wire [15:0] freq_thr;
   wire at_speed_nxt;
   wire freq_level_nxt;

   assign freq_diff = (out_freq_raw >= set_freq) ? (out_freq_raw - set_freq) :
      (set_freq - out_freq_raw);
   assign at_speed_nxt = scale(freq_diff, 8'h64) <=
      scale(set_freq, {1'b0, at_speed_band_setting_r});
   assign freq_thr = (rev_dir && rev_freq_threshold_r != `FCD_SENTINEL) ?
      rev_freq_threshold_r : fwd_freq_threshold_r;
   assign freq_level_nxt = out_freq_raw >= freq_thr;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         at_speed_flag_r <= 1'b0;
         freq_level_flag_r <= 1'b0;
      end else begin
         at_speed_flag_r <= at_speed_nxt && !dc_brake_active;
         freq_level_flag_r <= freq_level_nxt && !dc_brake_active;
      end
   end

   // =============================================
   // current conditions, percent of rated current
   wire [23:0] cur_scaled;
   wire oc_cond;
   wire zc_cond;
   wire oc_qual;
   wire zc_qual;

   assign cur_scaled = scale(out_current, 8'h64);
   assign oc_cond = running &&
      cur_scaled > scale(rated_current, overcurrent_level_setting_r);
   assign zc_cond = running && zero_current_level_setting_r != 8'h00 &&
      cur_scaled < scale(rated_current, zero_current_level_setting_r);

   fcd_qual_timer u_oc_timer (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick_r),
      .limit(overcurrent_delay_setting_r),
      .cond(oc_cond),
      .qualified_r(oc_qual)
   );

   fcd_qual_timer u_zc_timer (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick_r),
      .limit(zero_current_time_setting_r),
      .cond(zc_cond),
      .qualified_r(zc_qual)
   );

   // =============================================
   // overcurrent flag with retention and trip
   reg [13:0] oc_hold_r;
   wire oc_latch_mode;
   wire oc_hold_done;

   assign oc_latch_mode = {2'b00, overcurrent_retention_setting_r} == `FCD_SENTINEL;
   assign oc_hold_done = oc_hold_r >= overcurrent_retention_setting_r;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overcurrent_level_flag_r <= 1'b0;
         current_detect_fault_r <= 1'b0;
         oc_hold_r <= 14'h0000;
      end else begin
         // a new trip in the same cycle as the reset wins over it
         if (fault_reset) begin
            current_detect_fault_r <= 1'b0;
         end
         if (!overcurrent_level_flag_r) begin
            oc_hold_r <= 14'h0000;
            if (oc_qual) begin
               overcurrent_level_flag_r <= 1'b1;
               // action read only at turn-on, so a later change waits
               if (overcurrent_action_select_r) begin
                  current_detect_fault_r <= 1'b1;
               end
            end
         end else begin
            if (tick_r && !oc_hold_done) begin
               oc_hold_r <= oc_hold_r + 14'h0001;
            end
            if (oc_latch_mode) begin
               // tripped: only a fault reset frees it, else next start
               if (current_detect_fault_r ? fault_reset : start_cmd) begin
                  overcurrent_level_flag_r <= 1'b0;
               end
            end else if (oc_hold_done && (current_detect_fault_r || !oc_qual)) begin
               overcurrent_level_flag_r <= 1'b0;
            end
         end
      end
   end

   // =============================================
   // zero current flag with minimum on time
   localparam [13:0] ZC_HOLD_TICKS = `FCD_ZC_HOLD_MS / `FCD_TICK_MS;
   reg [13:0] zc_hold_r;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         zero_current_flag_r <= 1'b0;
         zc_hold_r <= 14'h0000;
      end else if (!zero_current_flag_r) begin
         zc_hold_r <= 14'h0000;
         zero_current_flag_r <= zc_qual;
      end else begin
         if (tick_r && zc_hold_r < ZC_HOLD_TICKS) begin
            zc_hold_r <= zc_hold_r + 14'h0001;
         end
         if (!zc_qual && zc_hold_r >= ZC_HOLD_TICKS) begin
            zero_current_flag_r <= 1'b0;
         end
      end
   end

   // =============================================
   // output terminals
   fcd_term_drive u_term_a (
      .clk(clk),
      .rst_n(rst_n),
      .func_code(terminal_function_select_a_r),
      .running(running),
      .at_speed(at_speed_flag_r),
      .freq_level(freq_level_flag_r),
      .oc_level(overcurrent_level_flag_r),
      .zc_level(zero_current_flag_r),
      .term_on_r(term_a_on)
   );

   fcd_term_drive u_term_b (
      .clk(clk),
      .rst_n(rst_n),
      .func_code(terminal_function_select_b_r),
      .running(running),
      .at_speed(at_speed_flag_r),
      .freq_level(freq_level_flag_r),
      .oc_level(overcurrent_level_flag_r),
      .zc_level(zero_current_flag_r),
      .term_on_r(term_b_on)
   );
endmodule // fcd_top

// *** tb_freq_current_detect_flags.sv ***
// self-checking bench for the frequency and current detection flags
`timescale 1ns/10ps
`include "fcd_defines.vh"
`define CHK(got, exp) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module tb_freq_current_detect_flags;
   // ==========================================
   // signals
   logic clk = 1'b0, rst_n = 1'b0, running = 1'b0, start_cmd = 1'b0, fault_reset = 1'b0;
   logic rev_dir = 1'b0, dc_brake_active = 1'b0, set_wr = 1'b0;
   logic [15:0] out_freq_raw = 16'h0000, set_freq = 16'h0000, out_current = 16'h0000;
   logic [15:0] rated_current = 16'h03e8, extended_settings_gate = 16'h0000, set_data = 16'h0000;
   logic [3:0] set_sel = 4'h0;
   logic [7:0] code_a = 8'h00, code_b = 8'h63;
   wire set_wr_refused_r, at_speed_flag_r, freq_level_flag_r, overcurrent_level_flag_r;
   wire zero_current_flag_r, current_detect_fault_r, term_a_on, term_b_on;
   wire flag_a_seen_r, flag_b_seen_r;
   int fail_count = 0;
   int total_checks = 0;
   int i;
   typedef struct {logic [15:0] rt; logic rev; logic brk; logic [15:0] f; logic [15:0] sp;
      logic su; logic fu;} fcd_row_t;
   // reverse threshold, direction, brake, output and set freq, expected flags
   fcd_row_t rows [10] = '{
      '{16'h270f, 1'b0, 1'b0, 16'h0258, 16'h0258, 1'b1, 1'b1},
      '{16'h270f, 1'b0, 1'b0, 16'h0294, 16'h0258, 1'b1, 1'b1},
      '{16'h270f, 1'b0, 1'b0, 16'h0295, 16'h0258, 1'b0, 1'b1},
      '{16'h270f, 1'b0, 1'b0, 16'h003c, 16'h0258, 1'b0, 1'b1},
      '{16'h270f, 1'b0, 1'b0, 16'h003b, 16'h0258, 1'b0, 1'b0},
      '{16'h270f, 1'b1, 1'b0, 16'h003c, 16'h0258, 1'b0, 1'b1},
      '{16'h00c8, 1'b1, 1'b0, 16'h00c7, 16'h0258, 1'b0, 1'b0},
      '{16'h00c8, 1'b1, 1'b0, 16'h00c8, 16'h0258, 1'b0, 1'b1},
      '{16'h00c8, 1'b0, 1'b0, 16'h003c, 16'h0258, 1'b0, 1'b1},
      '{16'h00c8, 1'b0, 1'b1, 16'h0258, 16'h0258, 1'b0, 1'b0}};

   always #4 clk = ~clk;

   // short tick so the 10 ms timebase fits the run
   fcd_top #(.TICK_CYCLES(4)) u_fcd_top (.clk(clk), .rst_n(rst_n), .running(running),
      .start_cmd(start_cmd), .fault_reset(fault_reset), .rev_dir(rev_dir),
      .dc_brake_active(dc_brake_active), .out_freq_raw(out_freq_raw), .set_freq(set_freq),
      .out_current(out_current), .rated_current(rated_current),
      .extended_settings_gate(extended_settings_gate), .set_wr(set_wr), .set_sel(set_sel),
      .set_data(set_data), .set_wr_refused_r(set_wr_refused_r),
      .at_speed_flag_r(at_speed_flag_r), .freq_level_flag_r(freq_level_flag_r),
      .overcurrent_level_flag_r(overcurrent_level_flag_r),
      .zero_current_flag_r(zero_current_flag_r), .current_detect_fault_r(current_detect_fault_r),
      .term_a_on(term_a_on), .term_b_on(term_b_on));
   fcd_machine_ctrl u_fcd_machine_ctrl (.clk(clk), .code_a(code_a), .code_b(code_b),
      .term_a_on(term_a_on), .term_b_on(term_b_on), .flag_a_seen_r(flag_a_seen_r),
      .flag_b_seen_r(flag_b_seen_r));

   // ==========================================
   // tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // extra idle cycle keeps set_wr from being driven twice in one step
   task automatic wr(input logic [3:0] sel, input logic [15:0] data, input logic refuse);
      set_wr = 1'b1;
      set_sel = sel;
      set_data = data;
      cyc(1);
      set_wr = 1'b0;
      `CHK(set_wr_refused_r, refuse)
      cyc(1);
   endtask
   task automatic set_terms(input logic [7:0] a, input logic [7:0] b);
      code_a = a;
      code_b = b;
      wr(`FCD_SEL_TERM_A, {8'h00, a}, 1'b0);
      wr(`FCD_SEL_TERM_B, {8'h00, b}, 1'b0);
   endtask
   function automatic logic flag_of(input int k);
      case (k)
         0: flag_of = overcurrent_level_flag_r;
         1: flag_of = current_detect_fault_r;
         default: flag_of = zero_current_flag_r;
      endcase
   endfunction
   task automatic wait_for(input int k, input logic lvl);
      int n;
      for (n = 0; n < 40 && flag_of(k) !== lvl; n++) cyc(1);
   endtask
   task automatic done(input string name);
      $display("test %s finished, mismatches so far %0d", name, fail_count);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #(8 * 20000);
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      close_out();
   end

   // ==========================================
   // main sequence
   initial begin
      cyc(4);
      rst_n = 1'b1;
      `CHK({overcurrent_level_flag_r, zero_current_flag_r, current_detect_fault_r, term_a_on}, 4'h0)
      done("reset");
      set_terms(`FCD_CODE_SU, `FCD_CODE_FU + `FCD_CODE_NEG);
      for (i = 0; i < 10; i++) begin
         wr(`FCD_SEL_REV_THR, rows[i].rt, 1'b0);
         rev_dir = rows[i].rev;
         dc_brake_active = rows[i].brk;
         out_freq_raw = rows[i].f;
         set_freq = rows[i].sp;
         cyc(4);
         `CHK(at_speed_flag_r, rows[i].su)
         `CHK(freq_level_flag_r, rows[i].fu)
         `CHK({flag_a_seen_r, flag_b_seen_r}, {rows[i].su, rows[i].fu})
      end
      dc_brake_active = 1'b0;
      rev_dir = 1'b0;
      done("frequency table");
      // band edge: 601 against 600 needs a nonzero band
      out_freq_raw = 16'h0259;
      extended_settings_gate = 16'h0001;
      wr(`FCD_SEL_BAND, 16'h0000, 1'b1);
      extended_settings_gate = 16'h0000;
      wr(`FCD_SEL_BAND, 16'h0065, 1'b1);
      wr(4'hb, 16'h0000, 1'b1);
      `CHK(at_speed_flag_r, 1'b1)
      wr(`FCD_SEL_BAND, 16'h0000, 1'b0);
      cyc(1);
      `CHK(at_speed_flag_r, 1'b0)
      done("setting gate");
      set_terms(`FCD_CODE_OC, `FCD_CODE_OC + `FCD_CODE_NEG);
      wr(`FCD_SEL_OC_DELAY, 16'h0003, 1'b0);
      running = 1'b1;
      out_current = 16'h05dc;
      cyc(30);
      `CHK(overcurrent_level_flag_r, 1'b0)
      out_current = 16'h05dd;
      cyc(6);
      out_current = 16'h05dc;
      cyc(1);
      out_current = 16'h05dd;
      cyc(8);
      `CHK(overcurrent_level_flag_r, 1'b0)
      wait_for(0, 1'b1);
      `CHK({overcurrent_level_flag_r, current_detect_fault_r}, 2'b10)
      out_current = 16'h01f4;
      cyc(3);
      `CHK({flag_a_seen_r, term_b_on}, 2'b10)
      cyc(25);
      `CHK(overcurrent_level_flag_r, 1'b1)
      wait_for(0, 1'b0);
      `CHK(overcurrent_level_flag_r, 1'b0)
      done("overcurrent level");
      wr(`FCD_SEL_OC_RETAIN, 16'h270f, 1'b0);
      wr(`FCD_SEL_OC_ACTION, 16'h0001, 1'b0);
      out_current = 16'h05dd;
      wait_for(1, 1'b1);
      `CHK({overcurrent_level_flag_r, current_detect_fault_r}, 2'b11)
      out_current = 16'h01f4;
      cyc(60);
      `CHK(overcurrent_level_flag_r, 1'b1)
      fault_reset = 1'b1;
      cyc(1);
      fault_reset = 1'b0;
      cyc(1);
      `CHK({overcurrent_level_flag_r, current_detect_fault_r}, 2'b00)
      wr(`FCD_SEL_OC_ACTION, 16'h0000, 1'b0);
      out_current = 16'h05dd;
      wait_for(0, 1'b1);
      wr(`FCD_SEL_OC_ACTION, 16'h0001, 1'b0);
      out_current = 16'h01f4;
      cyc(20);
      `CHK({overcurrent_level_flag_r, current_detect_fault_r}, 2'b10)
      start_cmd = 1'b1;
      cyc(1);
      start_cmd = 1'b0;
      cyc(1);
      `CHK(overcurrent_level_flag_r, 1'b0)
      out_current = 16'h05dd;
      wait_for(1, 1'b1);
      `CHK({overcurrent_level_flag_r, current_detect_fault_r}, 2'b11)
      out_current = 16'h01f4;
      cyc(10);
      fault_reset = 1'b1;
      cyc(1);
      fault_reset = 1'b0;
      wr(`FCD_SEL_OC_ACTION, 16'h0000, 1'b0);
      done("trip and latch");
      set_terms(`FCD_CODE_ZC, `FCD_CODE_ZC + `FCD_CODE_NEG);
      wr(`FCD_SEL_ZC_TIME, 16'h0002, 1'b0);
      out_current = 16'h0031;
      wait_for(2, 1'b1);
      `CHK(zero_current_flag_r, 1'b1)
      out_current = 16'h01f4;
      cyc(30);
      `CHK({zero_current_flag_r, flag_a_seen_r, term_b_on}, 3'b110)
      wait_for(2, 1'b0);
      `CHK(zero_current_flag_r, 1'b0)
      wr(`FCD_SEL_ZC_LEVEL, 16'h0000, 1'b0);
      out_current = 16'h0000;
      cyc(30);
      `CHK(zero_current_flag_r, 1'b0)
      done("zero current");
      // second reset mid-run must restore the reverse threshold sentinel
      rst_n = 1'b0;
      cyc(1);
      `CHK({zero_current_flag_r, overcurrent_level_flag_r, current_detect_fault_r}, 3'b000)
      rst_n = 1'b1;
      rev_dir = 1'b1;
      out_freq_raw = 16'h003c;
      cyc(2);
      `CHK({freq_level_flag_r, term_a_on, term_b_on}, 3'b110)
      done("mid-run reset");
      close_out();
   end
endmodule // tb_freq_current_detect_flags
